// [hw/edge_timer_pkg.sv]
package edge_timer_pkg;

  // bus geometry
  localparam int          ADDR_W       = 18;
  localparam int          DATA_W       = 32;
  localparam int          IDX_W        = 16;
  localparam int          CNT_W        = 8;

  // register indices, byte address is four times the index
  localparam logic [15:0] IDX_MODE_CTL = 16'hFFBC;
  localparam logic [15:0] IDX_FALL_CAP = 16'hFFBD;
  localparam logic [15:0] IDX_RISE_CAP = 16'hFFBE;
  localparam logic [15:0] IDX_PORT_MOD = 16'hFFBF;
  localparam logic [15:0] IDX_IRQ_CTL  = 16'hFFC0;

  // timer_mode_control fields
  localparam int          B_OVF_HIGH   = 7;
  localparam int          B_OVF_LOW    = 6;
  localparam int          B_OVF_IE     = 5;
  localparam int          B_CAP_EDGE   = 4;
  localparam int          B_CLR_HI     = 3;
  localparam int          B_CLR_LO     = 2;
  localparam int          B_CKS_HI     = 1;
  localparam int          B_CKS_LO     = 0;
  localparam logic [7:0]  MODE_RESET   = 8'h00;

  // port_mode_reg_one and irq control fields
  localparam int          B_CAP_SEL    = 0;
  localparam int          B_REQ_FLAG   = 0;
  localparam int          B_IRQ_GATE   = 1;

  // clock select codes
  localparam logic [1:0]  CKS_DIV64    = 2'h0;
  localparam logic [1:0]  CKS_DIV32    = 2'h1;
  localparam logic [1:0]  CKS_DIV2     = 2'h2;
  localparam logic [1:0]  CKS_WDIV2    = 2'h3;

  // counter clear codes
  localparam logic [1:0]  CLR_NONE     = 2'h0;
  localparam logic [1:0]  CLR_FALL     = 2'h1;
  localparam logic [1:0]  CLR_RISE     = 2'h2;
  localparam logic [1:0]  CLR_BOTH     = 2'h3;

  // prescaler terminal counts
  localparam int          PRE_W        = 6;
  localparam logic [5:0]  PRE_END64    = 6'h3F;
  localparam logic [4:0]  PRE_END32    = 5'h1F;
  localparam logic [7:0]  CNT_MAX      = 8'hFF;
  localparam logic [7:0]  CNT_ZERO     = 8'h00;

  // axi responses
  localparam logic [1:0]  RESP_OKAY    = 2'h0;
  localparam logic [1:0]  RESP_SLVERR  = 2'h2;

endpackage

// [hw/edge_capture_interval_timer8.sv]
// Added by the designer: the AXI4-Lite slave port.
`timescale 1ns/10ps
// Overview of operation
// - eight-bit up-counter advances once per pulse of the selected count clock
// - clock select 00 div64, 01 div32, 10 div2, 11 watch clock div2
// - capture select bit 1 gives capture timer, 0 gives plain interval timer
// - falling edge of capture input copies counter into falling-edge capture register
// - rising edge of capture input copies counter into rising-edge capture register
// - capture raises request flag only at edge chosen: 0 rising, 1 falling
// - interrupt output needs request flag set and separate enable bit set
// - clear bits: 00 never, 01 falling, 10 rising, 11 both edges
// - wrap from max to zero with input high sets high-overflow flag bit 7
// - wrap with input low, or any wrap in interval mode, sets bit 6
// - overflow flags set by hardware only; clear by writing 0 after reading 1
// - overflow enable bit 5 lets counter overflow raise the request flag
// - counter has no software access; only capture registers reveal it
// - reset zeroes counter, mode control register and both capture registers
// - capture registers are read-only; writes leave them unchanged
// - in subclock modes counter runs only with watch clock div2 selected
// - after reset counter counts system clock div64 at once
module edge_capture_interval_timer8
  import edge_timer_pkg::*;
(
  // clock and reset
  input  wire logic              aclk,
  input  wire logic              aresetn,
  // axi4-lite write address
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic [2:0]        s_axi_awprot,
  input  wire logic              s_axi_awvalid,
  output      logic              s_axi_awready,
  // axi4-lite write data
  input  wire logic [DATA_W-1:0] s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output      logic              s_axi_wready,
  // axi4-lite write response
  output      logic [1:0]        s_axi_bresp,
  output      logic              s_axi_bvalid,
  input  wire logic              s_axi_bready,
  // axi4-lite read address
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic [2:0]        s_axi_arprot,
  input  wire logic              s_axi_arvalid,
  output      logic              s_axi_arready,
  // axi4-lite read data
  output      logic [DATA_W-1:0] s_axi_rdata,
  output      logic [1:0]        s_axi_rresp,
  output      logic              s_axi_rvalid,
  input  wire logic              s_axi_rready,
  // external pins
  input  wire logic              capture_pin,
  input  wire logic              watch_clk_pin,
  input  wire logic              sub_mode_pin,
  // interrupt request to the cpu
  output      logic              timer_irq
);

  // synchronisers: stage one feeds stage two only
  logic [1:0]       cap_sync_r;
  logic [1:0]       wclk_sync_r;
  logic [1:0]       sub_sync_r;
  logic             cap_prev_r;
  logic             wclk_prev_r;
  logic             wdiv_r;
  logic [PRE_W-1:0] pre_r;

  // timer state
  logic [CNT_W-1:0] tick_counter_r;
  logic [CNT_W-1:0] fall_edge_capture_r;
  logic [CNT_W-1:0] rise_edge_capture_r;
  logic [5:0]       mode_ctl_r;
  logic             overflow_high_flag_r;
  logic             overflow_low_flag_r;
  logic [1:0]       flag_seen_r;
  logic             capture_pin_select_r;
  logic             timer_request_flag_r;
  logic             timer_irq_gate_r;

  // bus state
  logic              aw_held_r;
  logic              w_held_r;
  logic [IDX_W-1:0]  aw_idx_r;
  logic [DATA_W-1:0] wdata_r;
  logic              wstrb0_r;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      cap_sync_r  <= 2'h0;
      wclk_sync_r <= 2'h0;
      sub_sync_r  <= 2'h0;
    end else begin
      cap_sync_r  <= {cap_sync_r[0], capture_pin};
      wclk_sync_r <= {wclk_sync_r[0], watch_clk_pin};
      sub_sync_r  <= {sub_sync_r[0], sub_mode_pin};
    end
  end

  // only stage two is read, so a metastable stage one never reaches logic
  wire cap_lvl  = cap_sync_r[1];
  wire wclk_lvl = wclk_sync_r[1];
  wire sub_mode = sub_sync_r[1];

  wire cap_rise = capture_pin_select_r & cap_lvl & ~cap_prev_r;
  wire cap_fall = capture_pin_select_r & ~cap_lvl & cap_prev_r;

  // field views of the mode register
  // flags live apart from the writable bits, so writes cannot set them
  wire [1:0] cks      = mode_ctl_r[B_CKS_HI:B_CKS_LO];
  wire [1:0] clr_sel  = mode_ctl_r[B_CLR_HI:B_CLR_LO];
  wire       cap_edge = mode_ctl_r[B_CAP_EDGE];
  wire       ovf_ie   = mode_ctl_r[B_OVF_IE];

  // internal clock pulses
  // one free-running prescaler serves all three system clock taps
  wire tick_div64 = (pre_r == PRE_END64);
  wire tick_div32 = (pre_r[4:0] == PRE_END32);
  wire tick_div2  = pre_r[0];
  // watch clock halved: count every second synchronised rising edge
  // limitation: the watch clock must stay well below half of aclk
  wire tick_wdiv2 = wclk_lvl & ~wclk_prev_r & wdiv_r;

  wire tick_sel = (cks == CKS_DIV64) ? tick_div64 :
                  (cks == CKS_DIV32) ? tick_div32 :
                  (cks == CKS_DIV2)  ? tick_div2  : tick_wdiv2;

  wire run_ok   = ~sub_mode | (cks == CKS_WDIV2);
  wire tick     = tick_sel & run_ok;

  wire clr_hit  = ((clr_sel == CLR_FALL) & cap_fall) |
                  ((clr_sel == CLR_RISE) & cap_rise) |
                  ((clr_sel == CLR_BOTH) & (cap_rise | cap_fall));

  // a clear in the wrap cycle wins, so no overflow is reported then
  wire ovf      = tick & ~clr_hit & (tick_counter_r == CNT_MAX);
  wire ovf_hi   = ovf & capture_pin_select_r & cap_lvl;
  wire ovf_lo   = ovf & ~(capture_pin_select_r & cap_lvl);

  wire cap_req  = cap_edge ? cap_fall : cap_rise;
  wire req_set  = cap_req | (ovf & ovf_ie);

  // write channel decode
  wire              aw_hs   = s_axi_awvalid & s_axi_awready;
  wire              w_hs    = s_axi_wvalid & s_axi_wready;
  wire              aw_have = aw_held_r | aw_hs;
  wire              w_have  = w_held_r | w_hs;
  wire              do_wr   = aw_have & w_have & ~s_axi_bvalid;
  wire [IDX_W-1:0]  wr_idx  = aw_held_r ? aw_idx_r : s_axi_awaddr[ADDR_W-1:2];
  wire [DATA_W-1:0] wr_dat  = w_held_r ? wdata_r : s_axi_wdata;
  wire              wr_lane = w_held_r ? wstrb0_r : s_axi_wstrb[0];
  wire              wr_en   = do_wr & wr_lane;

  wire wr_mode  = wr_en & (wr_idx == IDX_MODE_CTL);
  wire wr_port  = wr_en & (wr_idx == IDX_PORT_MOD);
  wire wr_irq   = wr_en & (wr_idx == IDX_IRQ_CTL);
  // capture registers accept writes without effect
  wire wr_known = (wr_idx == IDX_MODE_CTL) | (wr_idx == IDX_FALL_CAP) |
                  (wr_idx == IDX_RISE_CAP) | (wr_idx == IDX_PORT_MOD) |
                  (wr_idx == IDX_IRQ_CTL);

  // clear only after a read showed the flag set
  // a flag set after the read is not armed, so no late event is lost
  wire clr_overflow_high_flag = wr_mode & ~wr_dat[B_OVF_HIGH] & flag_seen_r[1];
  wire clr_overflow_low_flag = wr_mode & ~wr_dat[B_OVF_LOW] & flag_seen_r[0];
  wire clr_req  = wr_irq & ~wr_dat[B_REQ_FLAG];

  // bus handshake next values
  wire aw_held_nxt = aw_have & ~do_wr;
  wire w_held_nxt  = w_have & ~do_wr;
  wire bvalid_nxt  = do_wr | (s_axi_bvalid & ~s_axi_bready);

  // read channel decode
  wire             ar_hs   = s_axi_arvalid & s_axi_arready;
  wire [IDX_W-1:0] rd_idx  = s_axi_araddr[ADDR_W-1:2];
  wire             rd_mode = ar_hs & (rd_idx == IDX_MODE_CTL);
  wire             rvalid_nxt = ar_hs | (s_axi_rvalid & ~s_axi_rready);
  wire [7:0]       mode_view  = {overflow_high_flag_r, overflow_low_flag_r, mode_ctl_r};

  // counter has no entry here
  // unmapped indices read zero and answer with an error
  wire [7:0] rd_byte =
    (rd_idx == IDX_MODE_CTL) ? mode_view :
    (rd_idx == IDX_FALL_CAP) ? fall_edge_capture_r :
    (rd_idx == IDX_RISE_CAP) ? rise_edge_capture_r :
    (rd_idx == IDX_PORT_MOD) ? {7'h00, capture_pin_select_r} :
    (rd_idx == IDX_IRQ_CTL)  ? {6'h00, timer_irq_gate_r, timer_request_flag_r} : 8'h00;
  wire rd_known = (rd_idx == IDX_MODE_CTL) | (rd_idx == IDX_FALL_CAP) |
                  (rd_idx == IDX_RISE_CAP) | (rd_idx == IDX_PORT_MOD) |
                  (rd_idx == IDX_IRQ_CTL);

  // prescaler and watch clock divider
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      pre_r       <= '0;
      cap_prev_r  <= 1'b0;
      wclk_prev_r <= 1'b0;
      wdiv_r      <= 1'b0;
    end else begin
      pre_r       <= pre_r + 1'b1;
      cap_prev_r  <= cap_lvl;
      wclk_prev_r <= wclk_lvl;
      if (wclk_lvl & ~wclk_prev_r) begin
        wdiv_r <= ~wdiv_r;
      end
    end
  end

  // counter with clear, reset and div64 start
  // a clear edge beats a tick in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      tick_counter_r <= CNT_ZERO;
    end else if (clr_hit) begin
      tick_counter_r <= CNT_ZERO;
    end else if (tick) begin
      tick_counter_r <= tick_counter_r + 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      fall_edge_capture_r <= CNT_ZERO;
      rise_edge_capture_r <= CNT_ZERO;
    end else begin
      if (cap_fall) begin
        fall_edge_capture_r <= tick_counter_r;
      end
      if (cap_rise) begin
        rise_edge_capture_r <= tick_counter_r;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mode_ctl_r           <= MODE_RESET[5:0];
      capture_pin_select_r <= 1'b0;
      timer_irq_gate_r     <= 1'b0;
    end else begin
      if (wr_mode) begin
        mode_ctl_r <= wr_dat[5:0];
      end
      if (wr_port) begin
        capture_pin_select_r <= wr_dat[B_CAP_SEL];
      end
      if (wr_irq) begin
        timer_irq_gate_r <= wr_dat[B_IRQ_GATE];
      end
    end
  end

  // overflow flags, a set wins over a clear
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      overflow_high_flag_r <= 1'b0;
      overflow_low_flag_r  <= 1'b0;
      flag_seen_r          <= 2'h0;
    end else begin
      overflow_high_flag_r <= ovf_hi | (overflow_high_flag_r & ~clr_overflow_high_flag);
      overflow_low_flag_r  <= ovf_lo | (overflow_low_flag_r & ~clr_overflow_low_flag);
      if (rd_mode) begin
        flag_seen_r <= {overflow_high_flag_r, overflow_low_flag_r};
      end else if (wr_mode) begin
        flag_seen_r <= 2'h0;
      end
    end
  end

  // request flag, gated output
  // a new request beats a software clear in the same cycle
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      timer_request_flag_r <= 1'b0;
      timer_irq            <= 1'b0;
    end else begin
      timer_request_flag_r <= req_set | (timer_request_flag_r & ~clr_req);
      timer_irq            <= timer_request_flag_r & timer_irq_gate_r;
    end
  end

  // write channel: address and data taken in either order
  // bvalid blocks both readies, so at most one response is owed
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r     <= 1'b0;
      w_held_r      <= 1'b0;
      aw_idx_r      <= '0;
      wdata_r       <= '0;
      wstrb0_r      <= 1'b0;
      s_axi_awready <= 1'b0;
      s_axi_wready  <= 1'b0;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= RESP_OKAY;
    end else begin
      aw_held_r     <= aw_held_nxt;
      w_held_r      <= w_held_nxt;
      s_axi_awready <= ~aw_held_nxt & ~bvalid_nxt;
      s_axi_wready  <= ~w_held_nxt & ~bvalid_nxt;
      s_axi_bvalid  <= bvalid_nxt;
      if (aw_hs) begin
        aw_idx_r <= s_axi_awaddr[ADDR_W-1:2];
      end
      if (w_hs) begin
        wdata_r  <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
      if (do_wr) begin
        s_axi_bresp <= wr_known ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

  // read channel: one read in flight, data latched at address handshake
  // rdata is frozen until rready, so a slow master sees a stable byte
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= '0;
      s_axi_rresp   <= RESP_OKAY;
    end else begin
      s_axi_arready <= ~rvalid_nxt;
      s_axi_rvalid  <= rvalid_nxt;
      if (ar_hs) begin
        s_axi_rdata <= {24'h000000, rd_byte};
        s_axi_rresp <= rd_known ? RESP_OKAY : RESP_SLVERR;
      end
    end
  end

endmodule

// [bench/edge_timer_sva.sv]
`timescale 1ns/10ps
module edge_timer_chk (
  // clock and reset
  input wire logic        aclk,
  input wire logic        aresetn,
  // bus handshakes
  input wire logic        s_axi_awvalid,
  input wire logic        s_axi_awready,
  input wire logic        s_axi_wvalid,
  input wire logic        s_axi_wready,
  input wire logic [1:0]  s_axi_bresp,
  input wire logic        s_axi_bvalid,
  input wire logic        s_axi_bready,
  input wire logic        s_axi_arvalid,
  input wire logic        s_axi_arready,
  input wire logic [31:0] s_axi_rdata,
  input wire logic        s_axi_rvalid,
  input wire logic        s_axi_rready,
  // cpu request
  input wire logic        timer_irq
);
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);
  a_wr_answer:
    assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
      |=> s_axi_bvalid) else $error("write not answered");
  a_rd_answer:
    assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("read not answered");
  a_b_hold:
    assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
      else $error("write response dropped");
  a_r_hold:
    assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
      else $error("read data dropped");
  a_ar_busy:
    assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read taken while busy");
  a_aw_busy:
    assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
      else $error("write taken while busy");
  a_ready_back:
    assert property (s_axi_bvalid && s_axi_bready |=> !s_axi_bvalid && s_axi_awready)
      else $error("write path not reopened");
  a_rd_byte:
    assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
      else $error("read data beyond one byte");
  a_irq_reset:
    assert property (disable iff (1'b0) !aresetn |=> !timer_irq)
      else $error("request active in reset");
endmodule

bind edge_capture_interval_timer8 edge_timer_chk i_edge_timer_chk (
  .aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
  .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .timer_irq
);

// [bench/pulse_source.sv]
`timescale 1ns/10ps
module pulse_source (
  // system clock
  input  wire logic aclk,
  // pins toward the timer
  output      logic capture_pin,
  output      logic watch_clk_pin
);
  // watch crystal runs free, phase unrelated to aclk
  initial begin
    watch_clk_pin = 1'b0;
    #7;
    forever #160 watch_clk_pin = ~watch_clk_pin;
  end
  initial capture_pin = 1'b0;
  task automatic drive(input logic v, input int n);
    @(posedge aclk);
    capture_pin <= v;
    repeat ((n < 2) ? 2 : n) @(posedge aclk);
  endtask
endmodule

// [bench/tb_top.sv]
`timescale 1ns/10ps
module tb_top
  import edge_timer_pkg::*;
;
  logic              aclk, aresetn, capture_pin, watch_clk_pin, sub_mode_pin, timer_irq;
  logic [ADDR_W-1:0] s_axi_awaddr, s_axi_araddr;
  logic [DATA_W-1:0] s_axi_wdata, s_axi_rdata;
  logic [3:0]        s_axi_wstrb;
  logic [1:0]        s_axi_bresp, s_axi_rresp, rs, bq;
  logic              s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
  logic              s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
  logic              s_axi_rvalid, s_axi_rready;
  logic [7:0]        v, f, r;
  int                fails = 0;
  int                n_checks = 0;
  int                cyc = 0;
  localparam logic [7:0] T_MODE [8] = '{8'h00, 8'h01, 8'h02, 8'h06, 8'h0A, 8'h0E, 8'h0F, 8'h0E};
  localparam int         T_HI   [8] = '{20, 20, 20, 20, 40, 40, 640, 40};
  localparam int         T_LO   [8] = '{640, 320, 60, 60, 20, 20, 20, 20};
  localparam int         T_SEL  [8] = '{0, 0, 0, 1, 2, 2, 2, 2};
  localparam logic [7:0] T_EXP  [8] = '{8'h0A, 8'h0A, 8'h1E, 8'h1E, 8'h14, 8'h14, 8'h14, 8'h00};

  edge_capture_interval_timer8 i_edge_capture_interval_timer8 (
    .aclk, .aresetn, .s_axi_awaddr, .s_axi_awprot(3'h0), .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arprot(3'h0),
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
    .s_axi_rready, .capture_pin, .watch_clk_pin, .sub_mode_pin, .timer_irq
  );
  pulse_source i_src (.aclk, .capture_pin, .watch_clk_pin);

  initial begin
    aclk = 1'b0;
    forever #10 aclk = ~aclk;
  end

  task automatic wrap_up;
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    n_checks++;
    if (g !== e) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  // tick counts may land one either way of the edge latency
  task automatic near(input string n, input logic [7:0] e, input logic [7:0] g);
    logic [7:0] d;
    d = g - e;
    n_checks++;
    if (!(d === 8'h00 || d === 8'h01 || d === 8'hFF)) begin
      fails++;
      $display("wrong value %s expected %h seen %h", n, e, g);
    end
  endtask

  task automatic wr(input logic [15:0] i, input logic [7:0] d);
    logic a;
    logic w;
    a = 1'b1;
    w = 1'b1;
    s_axi_awaddr  <= {i, 2'b00};
    s_axi_wdata   <= {24'h0, d};
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid  <= 1'b1;
    while (a || w) begin
      @(posedge aclk);
      if (a && s_axi_awready) s_axi_awvalid <= 1'b0;
      if (w && s_axi_wready) s_axi_wvalid <= 1'b0;
      a = a && !s_axi_awready;
      w = w && !s_axi_wready;
    end
    do @(posedge aclk); while (!s_axi_bvalid);
    s_axi_bready <= 1'b1;
    do @(posedge aclk); while (!s_axi_bvalid);
    bq = s_axi_bresp;
    s_axi_bready <= 1'b0;
  endtask

  task automatic rd(input logic [15:0] i, output logic [7:0] d, output logic [1:0] q);
    s_axi_araddr  <= {i, 2'b00};
    s_axi_arvalid <= 1'b1;
    do @(posedge aclk); while (!s_axi_arready);
    s_axi_arvalid <= 1'b0;
    do @(posedge aclk); while (!s_axi_rvalid);
    s_axi_rready <= 1'b1;
    do @(posedge aclk); while (!s_axi_rvalid);
    d = s_axi_rdata[7:0];
    q = s_axi_rresp;
    s_axi_rready <= 1'b0;
  endtask

  task automatic rchk(input logic [15:0] i, input logic [7:0] e);
    logic [7:0] d;
    logic [1:0] q;
    rd(i, d, q);
    chk("register", e, d);
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 30000) begin
      fails++;
      wrap_up();
    end
  end

  initial begin
    {aresetn, sub_mode_pin, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
    {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr, s_axi_wdata} = '0;
    s_axi_wstrb = 4'hF;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    rchk(IDX_MODE_CTL, MODE_RESET);
    rchk(IDX_FALL_CAP, 8'h00);
    rchk(IDX_RISE_CAP, 8'h00);
    rd(16'h0010, v, rs);
    chk("unmapped resp", {6'h0, RESP_SLVERR}, {6'h0, rs});
    // captures around the select change are ignored
    wr(IDX_PORT_MOD, 8'h01);
    for (int i = 0; i < 8; i++) begin
      wr(IDX_MODE_CTL, T_MODE[i]);
      sub_mode_pin <= (i >= 6);
      i_src.drive(1'b0, 6);
      i_src.drive(1'b1, T_HI[i]);
      i_src.drive(1'b0, T_LO[i]);
      i_src.drive(1'b1, 6);
      rd(IDX_FALL_CAP, f, rs);
      rd(IDX_RISE_CAP, r, rs);
      v = (T_SEL[i] == 0) ? r - f : (T_SEL[i] == 1) ? r : f;
      near("capture", T_EXP[i], v);
    end
    sub_mode_pin <= 1'b0;
    wr(IDX_MODE_CTL, 8'h2A);
    i_src.drive(1'b0, 6);
    i_src.drive(1'b1, 530);
    i_src.drive(1'b0, 300);
    wr(IDX_IRQ_CTL, 8'h02);
    i_src.drive(1'b0, 230);
    rchk(IDX_MODE_CTL, 8'hEA);
    rchk(IDX_IRQ_CTL, 8'h03);
    chk("irq pin", 8'h01, {7'h0, timer_irq});
    wr(IDX_MODE_CTL, 8'hEA);
    wr(IDX_MODE_CTL, 8'h2A);
    rchk(IDX_MODE_CTL, 8'hEA);
    wr(IDX_MODE_CTL, 8'h2A);
    rchk(IDX_MODE_CTL, 8'h2A);
    wr(IDX_MODE_CTL, 8'h12);
    wr(IDX_IRQ_CTL, 8'h00);
    i_src.drive(1'b1, 8);
    rchk(IDX_IRQ_CTL, 8'h00);
    i_src.drive(1'b0, 8);
    rchk(IDX_IRQ_CTL, 8'h01);
    chk("irq pin", 8'h00, {7'h0, timer_irq});
    wr(IDX_IRQ_CTL, 8'h03);
    repeat (2) @(posedge aclk);
    chk("irq pin", 8'h01, {7'h0, timer_irq});
    wr(IDX_PORT_MOD, 8'h00);
    rd(IDX_FALL_CAP, f, rs);
    rd(IDX_RISE_CAP, r, rs);
    wr(IDX_IRQ_CTL, 8'h02);
    wr(IDX_MODE_CTL, 8'h02);
    i_src.drive(1'b1, 8);
    i_src.drive(1'b0, 8);
    i_src.drive(1'b1, 520);
    i_src.drive(1'b0, 6);
    rchk(IDX_MODE_CTL, 8'h42);
    rchk(IDX_IRQ_CTL, 8'h02);
    chk("irq pin", 8'h00, {7'h0, timer_irq});
    rchk(IDX_FALL_CAP, f);
    rchk(IDX_RISE_CAP, r);
    s_axi_wstrb <= 4'hE;
    wr(IDX_MODE_CTL, 8'h00);
    s_axi_wstrb <= 4'hF;
    rchk(IDX_MODE_CTL, 8'h42);
    rd(IDX_RISE_CAP, v, rs);
    wr(IDX_RISE_CAP, ~v);
    chk("write resp", {6'h0, RESP_OKAY}, {6'h0, bq});
    rchk(IDX_RISE_CAP, v);
    wr(16'h0010, 8'h55);
    chk("write resp", {6'h0, RESP_SLVERR}, {6'h0, bq});
    // second reset in mid-run, with non-zero state behind it
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk("irq pin", 8'h00, {7'h0, timer_irq});
    rchk(IDX_MODE_CTL, MODE_RESET);
    rchk(IDX_FALL_CAP, 8'h00);
    rchk(IDX_RISE_CAP, 8'h00);
    rchk(IDX_IRQ_CTL, 8'h00);
    wrap_up();
  end
endmodule
